/* rtl/tlm_top.sv */
// torque limit and speed/torque mode select for a motor drive
// assumes settings written over a plain register port, analog, pulse
// and serial values already on this clock, two digital input pins async
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module tlm_top
  import tlm_pkg::*;
#(
  parameter int TICK_CYC = TLM_TICK_CYC,
  parameter int RAMP_UNIT_CYC = TLM_RAMP_UNIT_CYC,
  parameter logic [15:0] RPW_VAL_RST = 16'h03e8
)
(
  input wire logic CLOCK, // 20 MHz clock
  input wire logic NRST, // async reset, low
  input wire logic [3:0] REG_ADDR, // register index
  input wire logic [31:0] REG_WDATA, // write data
  input wire logic REG_WR, // write strobe
  input wire logic REG_RD, // read strobe
  output logic [31:0] REG_RDATA, // read data, cycle after read
  input wire logic SWITCHOVER_PIN, // speed/torque switchover input
  input wire logic TORQUE_PROHIBIT_PIN, // torque control prohibit input
  input wire logic signed [15:0] ANALOG_IN_ONE, // 0.1 % units
  input wire logic signed [15:0] ANALOG_IN_TWO, // 0.1 % units
  input wire logic signed [15:0] ANALOG_IN_THREE, // 0.1 % units
  input wire logic signed [15:0] PULSE_INPUT_TERMINAL, // pulse value
  input wire logic signed [15:0] COMM_REF, // serial value
  input wire logic signed [15:0] SPEED_FB, // raw speed feedback
  input wire logic [15:0] RATED_TORQUE, // rated drive torque
  input wire logic REGEN_NOW, // drive regenerating
  input wire logic CONST_SPEED_NOW, // running at constant speed
  input wire logic DECEL_NOW, // decelerating
  output logic TORQUE_MODE, // 1 torque control active
  output logic LIMIT_EN, // torque limit enforced
  output logic [15:0] MOTOR_LIMIT, // motoring limit, 0.1 %
  output logic [15:0] REGEN_LIMIT, // regenerative limit, 0.1 %
  output logic REGEN_PWR_ACT, // regen power limit active
  output logic [15:0] REGEN_PWR_CAP, // regen power cap, 0.1 %
  output logic signed [15:0] TORQUE_REF, // torque reference, 0.1 %
  output logic DIR_REV, // 1 reverse run
  output logic [15:0] FWD_FREQ_MAX, // forward ceiling, 0.01 Hz
  output logic [15:0] REV_FREQ_MAX, // reverse ceiling, 0.01 Hz
  output logic signed [16:0] FREQ_CMD, // ramped frequency, 0.01 Hz
  output logic signed [15:0] SPEED_FILT // filtered speed
);
  // settings
  logic type_q;
  logic meth_q;
  logic [9:0] filt_q;
  logic [2:0] mot_src_q;
  logic [15:0] mot_dig_q;
  logic [3:0] reg_src_q;
  logic [15:0] reg_dig_q;
  logic [1:0] rpw_sel_q;
  logic [15:0] rpw_val_q;
  logic [2:0] tref_src_q;
  logic signed [15:0] tref_dig_q;
  logic [15:0] fwd_q;
  logic [15:0] rev_q;
  logic [22:0] acc_t_q;
  logic [22:0] dec_t_q;
  logic [15:0] fmax_q;
  // pin synchronisers and tick
  logic sw_s1_q;
  logic sw_s2_q;
  logic inh_s1_q;
  logic inh_s2_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  // derived values
  logic torque_d;
  logic signed [15:0] tref_d;
  logic [15:0] mot_lim_d;
  logic [15:0] reg_lim_d;
  logic [15:0] fwd_eff;
  logic [15:0] rev_eff;
  logic rpw_act_d;
  logic signed [16:0] ramp_tgt;
  logic [31:0] wdata_s;
  // output registers
  logic torque_q;
  logic lim_en_q;
  logic [15:0] mot_lim_q;
  logic [15:0] reg_lim_q;
  logic rpw_act_q;
  logic [15:0] rpw_cap_q;
  logic signed [15:0] tref_q;
  logic dir_rev_q;
  logic [15:0] fwd_out_q;
  logic [15:0] rev_out_q;
  logic [31:0] rdata_q;

  // pick one value by source code, min and max over inputs one and two
  function automatic logic signed [15:0] pick(
    input logic [3:0] code, input logic signed [15:0] dig,
    input logic signed [15:0] a1, input logic signed [15:0] a2,
    input logic signed [15:0] a3, input logic signed [15:0] p,
    input logic signed [15:0] c);
    logic signed [15:0] r;
    r = dig;
    case (tlm_src_t'(code))
      TLM_SRC_AIN1: r = a1;
      TLM_SRC_AIN2: r = a2;
      TLM_SRC_AIN3: r = a3;
      TLM_SRC_PULSE: r = p;
      TLM_SRC_COMM: r = c;
      TLM_SRC_MIN: r = (a1 < a2) ? a1 : a2;
      TLM_SRC_MAX: r = (a1 > a2) ? a1 : a2;
      default: r = dig;
    endcase
    return r;
  endfunction

  // magnitude held to the 0 .. 200 % range of a limit
  function automatic logic [15:0] sat_lim(input logic signed [15:0] v);
    logic [15:0] m;
    m = (v < 0) ? 16'(-v) : 16'(v);
    return (m > TLM_PCT_MAX) ? TLM_PCT_MAX : m;
  endfunction

  // two flip-flops on each digital input pin
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      sw_s1_q <= 1'b0;
      sw_s2_q <= 1'b0;
      inh_s1_q <= 1'b1; // speed until pins synced
      inh_s2_q <= 1'b1;
    end
    else
    begin
      sw_s1_q <= SWITCHOVER_PIN;
      sw_s2_q <= sw_s1_q;
      inh_s1_q <= TORQUE_PROHIBIT_PIN;
      inh_s2_q <= inh_s1_q;
    end
  end

  // 1 ms enable for the speed filter
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == 32'(TICK_CYC - 1))
    begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  assign wdata_s = REG_WDATA;

  // settings writes; out of range values are refused and old ones kept
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      type_q <= TLM_TYPE_RST;
      meth_q <= TLM_METH_RST;
      filt_q <= TLM_FILT_RST;
      mot_src_q <= 3'h0;
      mot_dig_q <= TLM_PCT150_RST;
      reg_src_q <= 4'h0;
      reg_dig_q <= TLM_PCT150_RST;
      rpw_sel_q <= 2'h0;
      rpw_val_q <= RPW_VAL_RST;
      tref_src_q <= 3'h0;
      tref_dig_q <= TLM_PCT150_RST;
      fwd_q <= TLM_FREQ_RST;
      rev_q <= TLM_FREQ_RST;
      acc_t_q <= TLM_RAMP_RST;
      dec_t_q <= TLM_RAMP_RST;
      fmax_q <= TLM_FREQ_RST;
    end
    else if (REG_WR)
    begin
      case (REG_ADDR)
        TLM_R_CTRL:
        begin
          type_q <= wdata_s[TLM_CTRL_TYPE_BIT];
          meth_q <= wdata_s[TLM_CTRL_METH_BIT];
        end
        TLM_R_FILT:
          if (wdata_s <= 32'(TLM_FILT_MAX))
            filt_q <= wdata_s[9:0];
        TLM_R_MOT_SRC:
          if (wdata_s <= 32'h7)
            mot_src_q <= wdata_s[2:0];
        TLM_R_MOT_DIG:
          if (wdata_s <= 32'(TLM_PCT_MAX))
            mot_dig_q <= wdata_s[15:0];
        TLM_R_REG_SRC:
          if (wdata_s <= 32'h8)
            reg_src_q <= wdata_s[3:0];
        TLM_R_REG_DIG:
          if (wdata_s <= 32'(TLM_PCT_MAX))
            reg_dig_q <= wdata_s[15:0];
        TLM_R_RPW_SEL:
          if (wdata_s <= 32'h3)
            rpw_sel_q <= wdata_s[1:0];
        TLM_R_RPW_VAL:
          if (wdata_s <= 32'(TLM_PCT_MAX))
            rpw_val_q <= wdata_s[15:0];
        TLM_R_TREF_SRC:
          if (wdata_s <= 32'h7)
            tref_src_q <= wdata_s[2:0];
        TLM_R_TREF_DIG:
          if ($signed(wdata_s) <= $signed(32'(TLM_PCT_MAX))
              && $signed(wdata_s) >= -$signed(32'(TLM_PCT_MAX)))
            tref_dig_q <= wdata_s[15:0];
        TLM_R_FWD_MAX:
          if (wdata_s <= 32'(fmax_q))
            fwd_q <= wdata_s[15:0];
        TLM_R_REV_MAX:
          if (wdata_s <= 32'(fmax_q))
            rev_q <= wdata_s[15:0];
        TLM_R_ACC_T:
          if (wdata_s <= 32'(TLM_RAMP_MAX))
            acc_t_q <= wdata_s[22:0];
        TLM_R_DEC_T:
          if (wdata_s <= 32'(TLM_RAMP_MAX))
            dec_t_q <= wdata_s[22:0];
        TLM_R_FMAX:
          if (wdata_s <= 32'h0000ffff)
            fmax_q <= wdata_s[15:0];
        default: ;
      endcase
    end
  end

  // active mode from type setting and the two digital input functions
  assign torque_d = !inh_s2_q && (sw_s2_q ? type_q : !type_q);

  // torque reference in percent of rated torque, sign gives direction
  assign tref_d = pick({1'b0, tref_src_q}, tref_dig_q, ANALOG_IN_ONE,
    ANALOG_IN_TWO, ANALOG_IN_THREE, PULSE_INPUT_TERMINAL, COMM_REF);

  // limits: speed mode by source codes, torque mode follow the reference
  always_comb
  begin
    mot_lim_d = sat_lim(pick({1'b0, mot_src_q}, mot_dig_q, ANALOG_IN_ONE,
      ANALOG_IN_TWO, ANALOG_IN_THREE, PULSE_INPUT_TERMINAL, COMM_REF));
    if (reg_src_q == 4'h0)
      reg_lim_d = mot_lim_d;
    else
      reg_lim_d = sat_lim(pick(reg_src_q, reg_dig_q, ANALOG_IN_ONE,
        ANALOG_IN_TWO, ANALOG_IN_THREE, PULSE_INPUT_TERMINAL, COMM_REF));
    if (torque_d)
    begin
      mot_lim_d = sat_lim(tref_d);
      reg_lim_d = sat_lim(tref_d);
    end
  end

  // regenerative power limiting by phase of operation
  always_comb
  begin
    case (tlm_rpw_t'(rpw_sel_q))
      TLM_RPW_ALL: rpw_act_d = 1'b1;
      TLM_RPW_CONST: rpw_act_d = CONST_SPEED_NOW;
      TLM_RPW_DECEL: rpw_act_d = DECEL_NOW;
      default: rpw_act_d = 1'b0;
    endcase
  end

  // ceilings never above the max output frequency
  assign fwd_eff = (fwd_q > fmax_q) ? fmax_q : fwd_q;
  assign rev_eff = (rev_q > fmax_q) ? fmax_q : rev_q;

  // output registers
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      torque_q <= 1'b0;
      lim_en_q <= 1'b0;
      mot_lim_q <= TLM_PCT150_RST;
      reg_lim_q <= TLM_PCT150_RST;
      rpw_act_q <= 1'b0;
      rpw_cap_q <= RPW_VAL_RST;
      tref_q <= 16'h0000;
      dir_rev_q <= 1'b0;
      fwd_out_q <= TLM_FREQ_RST;
      rev_out_q <= TLM_FREQ_RST;
    end
    else
    begin
      torque_q <= torque_d;
      lim_en_q <= meth_q;
      mot_lim_q <= mot_lim_d;
      reg_lim_q <= reg_lim_d;
      rpw_act_q <= rpw_act_d && REGEN_NOW;
      rpw_cap_q <= rpw_val_q;
      tref_q <= torque_d ? tref_d : 16'h0000;
      dir_rev_q <= torque_d && tref_d < 0;
      fwd_out_q <= fwd_eff;
      rev_out_q <= rev_eff;
    end
  end

  // torque mode runs toward the ceiling of the reference's direction
  assign ramp_tgt = (tref_d < 0) ? -$signed({1'b0, rev_eff})
    : $signed({1'b0, fwd_eff});

  // ramped frequency command in torque control
  tlm_ramp #(
    .UNIT_CYC(RAMP_UNIT_CYC)
  ) u_ramp (
    .clk(CLOCK),
    .rst_n(NRST),
    .en(torque_q),
    .target(ramp_tgt),
    .fmax(fmax_q),
    .acc_t(acc_t_q),
    .dec_t(dec_t_q),
    .out(FREQ_CMD)
  );

  // speed feedback filter in the sensorless method only
  tlm_lpf u_lpf (
    .clk(CLOCK),
    .rst_n(NRST),
    .en(!meth_q),
    .tick(tick_q),
    .tau_ms(filt_q),
    .x(SPEED_FB),
    .y(SPEED_FILT)
  );

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      rdata_q <= 32'h0;
    else if (!REG_RD)
      rdata_q <= 32'h0;
    else
    begin
      case (REG_ADDR)
        TLM_R_CTRL: rdata_q <= {30'h0, meth_q, type_q};
        TLM_R_FILT: rdata_q <= {22'h0, filt_q};
        TLM_R_MOT_SRC: rdata_q <= {29'h0, mot_src_q};
        TLM_R_MOT_DIG: rdata_q <= {16'h0, mot_dig_q};
        TLM_R_REG_SRC: rdata_q <= {28'h0, reg_src_q};
        TLM_R_REG_DIG: rdata_q <= {16'h0, reg_dig_q};
        TLM_R_RPW_SEL: rdata_q <= {30'h0, rpw_sel_q};
        TLM_R_RPW_VAL: rdata_q <= {16'h0, rpw_val_q};
        TLM_R_TREF_SRC: rdata_q <= {29'h0, tref_src_q};
        TLM_R_TREF_DIG: rdata_q <= 32'(tref_dig_q);
        TLM_R_FWD_MAX: rdata_q <= {16'h0, fwd_q};
        TLM_R_REV_MAX: rdata_q <= {16'h0, rev_q};
        TLM_R_ACC_T: rdata_q <= {9'h0, acc_t_q};
        TLM_R_DEC_T: rdata_q <= {9'h0, dec_t_q};
        TLM_R_FMAX: rdata_q <= {16'h0, fmax_q};
        default: rdata_q <= {RATED_TORQUE, 12'h0, dir_rev_q, rpw_act_q,
          lim_en_q, torque_q};
      endcase
    end
  end

  assign REG_RDATA = rdata_q;
  assign TORQUE_MODE = torque_q;
  assign LIMIT_EN = lim_en_q;
  assign MOTOR_LIMIT = mot_lim_q;
  assign REGEN_LIMIT = reg_lim_q;
  assign REGEN_PWR_ACT = rpw_act_q;
  assign REGEN_PWR_CAP = rpw_cap_q;
  assign TORQUE_REF = tref_q;
  assign DIR_REV = dir_rev_q;
  assign FWD_FREQ_MAX = fwd_out_q;
  assign REV_FREQ_MAX = rev_out_q;
endmodule // tlm_top
`default_nettype wire

/* rtl/tlm_pkg.sv */
// constants shared by the torque limit and mode select block
// assumes a single 20 MHz clock and settings held in 0.1 %, 0.01 Hz,
// 1 ms and 10 ms units
package tlm_pkg;
  // register bus shape
  localparam int TLM_DW = 32;
  localparam int TLM_AW = 4;
  // clock and time bases
  localparam int TLM_CLK_HZ = 20_000_000;
  localparam int TLM_TICK_MS = 1;
  localparam int TLM_TICK_CYC = TLM_CLK_HZ / 1000 * TLM_TICK_MS;
  localparam int TLM_RAMP_UNIT_MS = 10;
  localparam int TLM_RAMP_UNIT_CYC = TLM_CLK_HZ / 1000 * TLM_RAMP_UNIT_MS;
  // register offsets (word index)
  localparam logic [3:0] TLM_R_CTRL = 4'h0;
  localparam logic [3:0] TLM_R_FILT = 4'h1;
  localparam logic [3:0] TLM_R_MOT_SRC = 4'h2;
  localparam logic [3:0] TLM_R_MOT_DIG = 4'h3;
  localparam logic [3:0] TLM_R_REG_SRC = 4'h4;
  localparam logic [3:0] TLM_R_REG_DIG = 4'h5;
  localparam logic [3:0] TLM_R_RPW_SEL = 4'h6;
  localparam logic [3:0] TLM_R_RPW_VAL = 4'h7;
  localparam logic [3:0] TLM_R_TREF_SRC = 4'h8;
  localparam logic [3:0] TLM_R_TREF_DIG = 4'h9;
  localparam logic [3:0] TLM_R_FWD_MAX = 4'ha;
  localparam logic [3:0] TLM_R_REV_MAX = 4'hb;
  localparam logic [3:0] TLM_R_ACC_T = 4'hc;
  localparam logic [3:0] TLM_R_DEC_T = 4'hd;
  localparam logic [3:0] TLM_R_FMAX = 4'he;
  localparam logic [3:0] TLM_R_STATUS = 4'hf;
  // ctrl field positions
  localparam int TLM_CTRL_TYPE_BIT = 0;
  localparam int TLM_CTRL_METH_BIT = 1;
  // setting limits
  localparam logic [15:0] TLM_PCT_MAX = 16'h07d0;
  localparam logic [9:0] TLM_FILT_MAX = 10'h3e8;
  localparam logic [22:0] TLM_RAMP_MAX = 23'h632ea0;
  // values after reset
  localparam logic TLM_TYPE_RST = 1'b0;
  localparam logic TLM_METH_RST = 1'b0;
  localparam logic [9:0] TLM_FILT_RST = 10'h00f;
  localparam logic [15:0] TLM_PCT150_RST = 16'h05dc;
  localparam logic [15:0] TLM_FREQ_RST = 16'h1388;
  localparam logic [22:0] TLM_RAMP_RST = 23'h000000;
  // source codes
  typedef enum logic [3:0] {
    TLM_SRC_DIG, TLM_SRC_AIN1, TLM_SRC_AIN2, TLM_SRC_AIN3,
    TLM_SRC_PULSE, TLM_SRC_COMM, TLM_SRC_MIN, TLM_SRC_MAX, TLM_SRC_REG_DIG
  } tlm_src_t;
  // regenerative power limit selections
  typedef enum logic [1:0] {
    TLM_RPW_OFF, TLM_RPW_ALL, TLM_RPW_CONST, TLM_RPW_DECEL
  } tlm_rpw_t;
endpackage

/* rtl/tlm_lpf.sv */
// first order speed feedback filter, stepped by a 1 ms enable
// assumes tau in ms and a bypass when disabled or tau is zero
`timescale 1ns/100ps
`default_nettype none
module tlm_lpf
  import tlm_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, low
  input wire logic en, // filter in use
  input wire logic tick, // 1 ms enable
  input wire logic [9:0] tau_ms, // time constant
  input wire logic signed [15:0] x, // raw speed
  output logic signed [15:0] y // filtered speed
);
  logic signed [23:0] y_q;
  logic signed [24:0] diff;
  logic [3:0] k;

  // shift that approximates the time constant in ticks
  function automatic logic [3:0] shift_of(input logic [9:0] t);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 10; i++)
      if (t[i])
        s = 4'(i + 1);
    return s;
  endfunction

  assign k = shift_of(tau_ms);
  assign diff = {x[15], x, 8'h00} - {y_q[23], y_q};

  // filter state, bypassed outside the sensorless mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      y_q <= 24'h000000;
    else if (!en || tau_ms == 10'h000)
      y_q <= {x, 8'h00};
    else if (tick)
      y_q <= y_q + 24'(diff >>> k);
  end

  assign y = y_q[23:8];
endmodule // tlm_lpf
`default_nettype wire

/* rtl/tlm_ramp.sv */
// frequency ramp toward a signed target, one 0.01 Hz count per step, straight to the target when the ramp time is zero
// assumes ramp times in 10 ms units measured from zero to max frequency
`timescale 1ns/100ps
`default_nettype none
module tlm_ramp
  import tlm_pkg::*;
#(
  parameter int UNIT_CYC = TLM_RAMP_UNIT_CYC
)
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, low
  input wire logic en, // ramp running
  input wire logic signed [16:0] target, // wanted frequency
  input wire logic [15:0] fmax, // max frequency
  input wire logic [22:0] acc_t, // accel time
  input wire logic [22:0] dec_t, // decel time
  output logic signed [16:0] out // ramped frequency
);
  logic signed [16:0] out_q;
  logic [47:0] acc_q;
  logic [47:0] sum;
  logic [47:0] thr;
  logic up;
  logic rising;

  assign up = target > out_q;
  assign rising = up ? (out_q >= 0) : (out_q <= 0);
  assign thr = 48'(rising ? acc_t : dec_t) * 48'(UNIT_CYC);
  assign sum = acc_q + 48'(fmax);

  // accumulate fmax per cycle; one step each time it passes the time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= 17'h00000;
      acc_q <= 48'h0;
    end
    else if (!en)
    begin
      out_q <= 17'h00000;
      acc_q <= 48'h0;
    end
    else if (out_q == target)
      acc_q <= 48'h0;
    else if (thr == 48'h0)
      out_q <= target;
    else if (sum >= thr)
    begin
      out_q <= up ? out_q + 17'sh1 : out_q - 17'sh1;
      acc_q <= sum - thr;
    end
    else
      acc_q <= sum;
  end

  assign out = out_q;
endmodule // tlm_ramp
`default_nettype wire

/* test/tlm_top_checker.sv */
// port-level assertions for the torque limit and mode select block
// assumes it is bound onto tlm_top, one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
module tlm_top_checker
  import tlm_pkg::*;
(
  input wire logic CLOCK, // clock
  input wire logic NRST, // reset, low
  input wire logic [3:0] REG_ADDR, // register index
  input wire logic [31:0] REG_WDATA, // write data
  input wire logic REG_WR, // write strobe
  input wire logic REG_RD, // read strobe
  input wire logic [31:0] REG_RDATA, // read data
  input wire logic TORQUE_PROHIBIT_PIN, // prohibit pin
  input wire logic [15:0] RATED_TORQUE, // rated torque
  input wire logic REGEN_NOW, // regenerating
  input wire logic TORQUE_MODE, // torque control
  input wire logic LIMIT_EN, // limits enforced
  input wire logic [15:0] MOTOR_LIMIT, // motoring limit
  input wire logic [15:0] REGEN_LIMIT, // regen limit
  input wire logic REGEN_PWR_ACT, // regen power limit on
  input wire logic signed [15:0] TORQUE_REF, // torque reference
  input wire logic DIR_REV, // reverse run
  input wire logic [15:0] FWD_FREQ_MAX, // forward ceiling
  input wire logic [15:0] REV_FREQ_MAX, // reverse ceiling
  input wire logic signed [16:0] FREQ_CMD // ramp output
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // multi-step causes
  sequence s_prohibit_held; TORQUE_PROHIBIT_PIN [*3]; endsequence
  sequence s_speed_held; (!TORQUE_MODE) [*3]; endsequence
  sequence s_ref_held; (TORQUE_MODE && $stable(TORQUE_REF)) [*2]; endsequence
  sequence s_ctrl_write; REG_WR && REG_ADDR == TLM_R_CTRL; endsequence
  sequence s_ceil_held; ($stable(FWD_FREQ_MAX) && $stable(REV_FREQ_MAX)) [*2]; endsequence
  property p_rd_idle; !$past(REG_RD) |-> REG_RDATA == 32'h0; endproperty
  property p_status;
    REG_RD && REG_ADDR == TLM_R_STATUS |=> REG_RDATA == {$past(RATED_TORQUE), 12'h000,
      $past(DIR_REV), $past(REGEN_PWR_ACT), $past(LIMIT_EN), $past(TORQUE_MODE)};
  endproperty
  property p_prohibit; s_prohibit_held |=> !TORQUE_MODE; endproperty
  property p_speed_zero;
    s_speed_held |-> TORQUE_REF == 16'sh0 && FREQ_CMD == 17'sh0 && !DIR_REV;
  endproperty
  property p_dir; s_ref_held |-> DIR_REV == (TORQUE_REF < 0); endproperty
  property p_limit_range; MOTOR_LIMIT <= TLM_PCT_MAX && REGEN_LIMIT <= TLM_PCT_MAX; endproperty
  property p_rpw_cause; REGEN_PWR_ACT |-> $past(REGEN_NOW); endproperty
  property p_method; s_ctrl_write |-> ##2 LIMIT_EN == $past(REG_WDATA[1], 2); endproperty
  property p_freq_bound;
    s_ceil_held |-> FREQ_CMD <= $signed({1'b0, FWD_FREQ_MAX})
      && FREQ_CMD >= -$signed({1'b0, REV_FREQ_MAX});
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_status: assert property (p_status) else $error("status word mismatch");
  a_prohibit: assert property (p_prohibit) else $error("torque mode while prohibited");
  a_speed_zero: assert property (p_speed_zero) else $error("torque path live in speed mode");
  a_dir: assert property (p_dir) else $error("direction does not follow reference sign");
  a_limit_range: assert property (p_limit_range) else $error("limit above full scale");
  a_rpw_cause: assert property (p_rpw_cause) else $error("regen power limit without regen");
  a_method: assert property (p_method) else $error("limit enable not from method bit");
  a_freq_bound: assert property (p_freq_bound) else $error("frequency past ceiling");
endmodule // tlm_top_checker
bind tlm_top tlm_top_checker chk_u (.CLOCK(CLOCK), .NRST(NRST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .TORQUE_PROHIBIT_PIN(TORQUE_PROHIBIT_PIN), .RATED_TORQUE(RATED_TORQUE),
  .REGEN_NOW(REGEN_NOW), .TORQUE_MODE(TORQUE_MODE), .LIMIT_EN(LIMIT_EN),
  .MOTOR_LIMIT(MOTOR_LIMIT), .REGEN_LIMIT(REGEN_LIMIT), .REGEN_PWR_ACT(REGEN_PWR_ACT),
  .TORQUE_REF(TORQUE_REF), .DIR_REV(DIR_REV), .FWD_FREQ_MAX(FWD_FREQ_MAX),
  .REV_FREQ_MAX(REV_FREQ_MAX), .FREQ_CMD(FREQ_CMD));
`default_nettype wire

/* test/tlm_operator.sv */
// model of the drive operator side: reference sources and speed sensor
// assumes the bench owns the register port and the digital inputs
`timescale 1ns/100ps
`default_nettype none
module tlm_operator
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset, low
  output logic signed [15:0] ain_one, // analog one
  output logic signed [15:0] ain_two, // analog two
  output logic signed [15:0] ain_three, // analog three
  output logic signed [15:0] pulse_val, // pulse source
  output logic signed [15:0] comm_val, // serial source
  output logic signed [15:0] speed_fb, // speed sensor
  output logic [15:0] rated_torque // rated torque, arbitrary value
);
  logic [12:0] cnt_q;
  // distinct source levels so every single-input source code is visible
  assign ain_one = 16'sh02bc;
  assign ain_two = 16'sh012c;
  assign ain_three = 16'sh0384;
  assign pulse_val = 16'sh044c;
  assign comm_val = 16'sh0514;
  assign rated_torque = 16'h1234;
  // speed steps between two levels every 4096 cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 13'h0;
    else
      cnt_q <= cnt_q + 13'h1;
  end
  assign speed_fb = cnt_q[12] ? 16'sh03e8 : -16'sh03e8;
endmodule // tlm_operator
`default_nettype wire

/* test/torque_limit_mode_select_bench.sv */
// self-checking bench for the torque limit and mode select block
// assumes tlm_top with short time bases and the operator model
`timescale 1ns/100ps
`default_nettype none
module torque_limit_mode_select_bench;
  import tlm_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sw_pin = 1'b1, pro_pin = 1'b0;
  logic regen_now = 1'b0, const_now = 1'b0, decel_now = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic signed [15:0] a1, a2, a3, pv, cv, sfb, tref, sfilt;
  logic [15:0] rt, mlim, rlim, rcap, fwd, rev;
  logic tmode, lim_en, rpw_act, dir_rev;
  logic signed [16:0] fcmd;
  logic [31:0] def_tab [15] = '{0, 15, 0, 1500, 0, 1500, 0, 1000, 0, 1500, 5000, 5000, 0, 0, 5000};
  logic [15:0] src_tab [8] = '{2000, 700, 300, 900, 1100, 1300, 300, 700};
  int errors = 0, cmp_count = 0, tick_cnt = 0;
  tlm_operator op_u (.clk(clock), .rst_n(nrst), .ain_one(a1), .ain_two(a2), .ain_three(a3),
    .pulse_val(pv), .comm_val(cv), .speed_fb(sfb), .rated_torque(rt));
  tlm_top #(.TICK_CYC(20), .RAMP_UNIT_CYC(2)) dut_u (.CLOCK(clock), .NRST(nrst),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .SWITCHOVER_PIN(sw_pin), .TORQUE_PROHIBIT_PIN(pro_pin),
    .ANALOG_IN_ONE(a1), .ANALOG_IN_TWO(a2), .ANALOG_IN_THREE(a3), .PULSE_INPUT_TERMINAL(pv),
    .COMM_REF(cv), .SPEED_FB(sfb), .RATED_TORQUE(rt), .REGEN_NOW(regen_now),
    .CONST_SPEED_NOW(const_now), .DECEL_NOW(decel_now), .TORQUE_MODE(tmode),
    .LIMIT_EN(lim_en), .MOTOR_LIMIT(mlim), .REGEN_LIMIT(rlim), .REGEN_PWR_ACT(rpw_act),
    .REGEN_PWR_CAP(rcap), .TORQUE_REF(tref), .DIR_REV(dir_rev), .FWD_FREQ_MAX(fwd),
    .REV_FREQ_MAX(rev), .FREQ_CMD(fcmd), .SPEED_FILT(sfilt));
  // 20 MHz clock
  always #25 clock = ~clock;
  // hang guard
  always @(posedge clock)
  begin
    tick_cnt++;
    if (tick_cnt == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    for (int a = 0; a < 15; a++)
      rchk("reg_default", a[3:0], def_tab[a]);
    rchk("status", TLM_R_STATUS, {16'h1234, 16'h0});
    chk("regen_lim_default", 1500, rlim);
    wr(TLM_R_MOT_DIG, 2001);
    rchk("mot_dig_refused", TLM_R_MOT_DIG, 1500);
    wr(TLM_R_MOT_DIG, 2000);
    cyc(2);
    chk("mot_lim_dig", 2000, mlim);
    chk("regen_lim_shared", 2000, rlim);
    for (int c = 1; c < 8; c++)
    begin
      wr(TLM_R_MOT_SRC, c);
      cyc(2);
      chk("mot_lim_src", src_tab[c], mlim);
    end
    wr(TLM_R_MOT_SRC, 8);
    rchk("mot_src_refused", TLM_R_MOT_SRC, 7);
    wr(TLM_R_MOT_SRC, 0);
    wr(TLM_R_REG_DIG, 600);
    wr(TLM_R_REG_SRC, 8);
    cyc(2);
    chk("regen_lim_dig", 600, rlim);
    chk("mot_lim_kept", 2000, mlim);
    wr(TLM_R_REG_SRC, 2);
    cyc(2);
    chk("regen_lim_src", 300, rlim);
    wr(TLM_R_RPW_VAL, 800);
    wr(TLM_R_RPW_VAL, 2001);
    rchk("rpw_val", TLM_R_RPW_VAL, 800);
    chk("rpw_cap", 800, rcap);
    for (int s = 0; s < 4; s++)
    begin
      wr(TLM_R_RPW_SEL, s);
      for (int k = 0; k < 8; k++)
      begin
        @(posedge clock);
        regen_now <= k[0];
        const_now <= k[1];
        decel_now <= k[2];
        cyc(2);
        chk("rpw_act", k[0] && (s == 1 || (s == 2 && k[1]) || (s == 3 && k[2])), rpw_act);
      end
    end
    wr(TLM_R_FILT, 1001);
    rchk("filt_refused", TLM_R_FILT, 15);
    wr(TLM_R_FILT, 1000);
    @(sfb);
    cyc(3);
    chk("filt_lag", 1, sfilt !== sfb);
    wr(TLM_R_CTRL, 2);
    cyc(3);
    chk("filt_bypass", sfb, sfilt);
    chk("limit_en", 1, lim_en);
    for (int m = 0; m < 8; m++)
    begin
      wr(TLM_R_CTRL, {30'h0, 1'b1, m[0]});
      sw_pin <= m[1];
      pro_pin <= m[2];
      cyc(5);
      chk("torque_mode", !m[2] && (m[1] ? m[0] : !m[0]), tmode);
    end
    wr(TLM_R_FWD_MAX, 3000);
    wr(TLM_R_REV_MAX, 4000);
    wr(TLM_R_FWD_MAX, 5001);
    cyc(2);
    chk("fwd_max", 3000, fwd);
    chk("rev_max", 4000, rev);
    wr(TLM_R_FMAX, 2000);
    cyc(2);
    chk("fwd_clamped", 2000, fwd);
    chk("rev_clamped", 2000, rev);
    wr(TLM_R_FMAX, 5000);
    sw_pin <= 1'b1;
    pro_pin <= 1'b0;
    cyc(6);
    chk("torque_on", 1, tmode);
    chk("tref_default", 1500, tref);
    chk("mot_lim_torque", 1500, mlim);
    chk("freq_jump", 3000, fcmd);
    wr(TLM_R_TREF_DIG, -500);
    cyc(5);
    chk("tref_neg", -500, tref);
    chk("dir_rev", 1, dir_rev);
    chk("freq_rev", -4000, fcmd);
    wr(TLM_R_TREF_DIG, -2001);
    rchk("tref_refused", TLM_R_TREF_DIG, -500);
    for (int c = 1; c < 8; c++)
    begin
      wr(TLM_R_TREF_SRC, c);
      cyc(2);
      chk("tref_src", src_tab[c], tref);
    end
    @(posedge clock);
    pro_pin <= 1'b1;
    cyc(5);
    chk("freq_speed", 0, fcmd);
    wr(TLM_R_ACC_T, 6500001);
    wr(TLM_R_ACC_T, 5000);
    rchk("acc_t", TLM_R_ACC_T, 5000);
    @(posedge clock);
    pro_pin <= 1'b0;
    cyc(104);
    chk("ramp_mid", 1, fcmd > 30 && fcmd < 80);
    wrap_up();
  end
endmodule // torque_limit_mode_select_bench
`default_nettype wire
